// ---- bench/flsr_host.sv ----
`timescale 1ns/1ps
module flsr_host
  import flsr_pkg::*;
(
  input wire logic link_clk,
  output logic link_req,
  output flsr_req_t link_cmd_in,
  input wire flsr_rsp_t link_rsp,
  input wire logic link_busy,
  input wire logic link_done
);
  // Extra idle link cycles before each request
  int slow = 0;

  initial begin
    link_req = 1'b0;
    link_cmd_in = '0;
  end

  // One request; the answer is taken at the rising edge where done stands
  task automatic xfer(input logic wr, input logic [7:0] cmd,
                      input logic [15:0] data, output flsr_rsp_t rsp);
    int n;
    n = 0;
    repeat (slow + 1) @(posedge link_clk);
    link_req <= 1'b1;
    link_cmd_in <= '{wr, cmd, data};
    @(posedge link_clk);
    link_req <= 1'b0;
    link_cmd_in <= ~link_cmd_in;
    do begin
      @(posedge link_clk);
      n++;
    end while (link_done !== 1'b1 && n < 20);
    // A lost answer comes back unknown so that every compare trips
    if (link_done === 1'b1) begin
      rsp = link_rsp;
    end else begin
      rsp = 'x;
    end
  endtask : xfer
endmodule : flsr_host

// ---- bench/flsr_regs_properties.sv ----
`timescale 1ns/1ps
module flsr_regs_properties
  import flsr_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = FLSR_CYC_PER_MS
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic link_req,
  input wire flsr_req_t link_cmd_in,
  input wire flsr_rsp_t link_rsp,
  input wire logic link_busy,
  input wire logic link_done,
  input wire flsr_pins_t fault_pins,
  input wire flsr_sense_t sense,
  input wire logic out_enable,
  input wire logic out_ramping,
  input wire logic power_good
);
  //////////////////////////////////////////////////////////////////////////
  logic take;
  assign take = link_req && !link_busy && !link_done;

  sequence s_rd(logic [7:0] c);
    take && !link_cmd_in.wr && link_cmd_in.cmd == c;
  endsequence
  sequence s_wr(logic [7:0] c);
    take && link_cmd_in.wr && link_cmd_in.cmd == c;
  endsequence
  //////////////////////////////////////////////////////////////////////////
  a_done_single:
  assert property (@(posedge link_clk) disable iff (sys_rst)
    link_done |=> !link_done) else $error("done wider than one cycle");
  a_busy_ends:
  assert property (@(posedge link_clk) disable iff (sys_rst)
    link_done |-> !link_busy) else $error("busy still high at done");
  a_busy_holds:
  assert property (@(posedge link_clk) disable iff (sys_rst)
    take |=> link_busy until link_done) else $error("busy dropped early");
  a_answer_time:
  assert property (@(posedge link_clk) disable iff (sys_rst)
    take |-> ##[4:8] link_done) else $error("answer out of time");
  a_ro_refused:
  assert property (@(posedge link_clk) disable iff (sys_rst)
    s_wr(FLSR_CMD_STATUS_WORD) |-> ##[4:8] (link_done && link_rsp.nack))
    else $error("read-only write accepted");
  a_ot_rsp_fixed:
  assert property (@(posedge link_clk) disable iff (sys_rst)
    s_rd(FLSR_CMD_OT_FAULT_RSP) |-> ##[4:8] (link_done
      && link_rsp.data[15:6] == 10'h002 && link_rsp.data[2:0] == 3'h0
      && (link_rsp.data[5:3] == 3'h0 || link_rsp.data[5:3] == 3'h7)))
    else $error("response byte malformed");
  a_vin_rsp_fixed:
  assert property (@(posedge link_clk) disable iff (sys_rst)
    s_rd(FLSR_CMD_VIN_OV_RSP) |-> ##[4:8] (link_done
      && link_rsp == 17'h000C0)) else $error("fixed response wrong");
  a_word_unsupp:
  assert property (@(posedge link_clk) disable iff (sys_rst)
    s_rd(FLSR_CMD_STATUS_WORD) |-> ##[4:8] (link_done
      && (link_rsp.data & 16'h1581) == 16'h0000))
    else $error("unsupported status bit set");
  a_ramp_in_enable:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    out_ramping |-> out_enable) else $error("ramping while disabled");
  a_pg_needs_on:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    power_good |-> $past(out_enable) && !out_ramping)
    else $error("power good outside on state");
  a_off_cmd_low:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    !fault_pins.on_cmd [*6] |-> !out_enable)
    else $error("enabled while commanded off");
endmodule : flsr_regs_properties

// ---- bench/flsr_regs_tb.sv ----
`timescale 1ns/1ps
module flsr_regs_tb
  import flsr_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic link_clk = 1'b0;
  logic link_req;
  flsr_req_t link_cmd_in;
  flsr_rsp_t link_rsp;
  logic link_busy;
  logic link_done;
  flsr_pins_t fault_pins;
  flsr_sense_t sense;
  logic out_enable;
  logic out_ramping;
  logic power_good;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;

  always #4 clk_sys = ~clk_sys;
  initial begin
    #3;
    forever #32 link_clk = ~link_clk;
  end

  flsr_regs #(.CYC_PER_MS(4)) flsr_regs_i (.clk_sys, .sys_rst, .link_clk,
    .link_req, .link_cmd_in, .link_rsp, .link_busy, .link_done,
    .fault_pins, .sense, .out_enable, .out_ramping, .power_good);
  flsr_host flsr_host_i (.link_clk, .link_req, .link_cmd_in, .link_rsp,
    .link_busy, .link_done);
  //////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      test_done;
    end
  end

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic rng(input int n, input int lo, input int hi);
    check(17'(n), (n >= lo && n <= hi) ? 17'(n) : 17'(lo));
  endtask : rng

  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic nk);
    flsr_rsp_t r;
    flsr_host_i.xfer(1'b1, c, d, r);
    check(17'(r.nack), 17'(nk));
  endtask : wr

  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    flsr_rsp_t r;
    flsr_host_i.xfer(1'b0, c, 16'h0000, r);
    check(r, {1'b0, e});
  endtask : rd

  task automatic wc(input logic [7:0] c, input logic [15:0] d, input logic nk,
                    input logic [15:0] e);
    wr(c, d, nk);
    rd(c, e);
  endtask : wc

  function automatic logic pick(input int s);
    return s == 0 ? out_enable : (s == 1 ? out_ramping : power_good);
  endfunction : pick

  task automatic wait_for(input int s, input logic v, input int lim,
                          output int n);
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask : wait_for
  //////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    rd(FLSR_CMD_OT_FAULT_LIM, 16'h007D);
    rd(FLSR_CMD_OT_FAULT_RSP, 16'h00B8);
    rd(FLSR_CMD_OT_WARN_LIM, 16'h006E);
    rd(FLSR_CMD_VIN_OV_LIM, 16'h0050);
    rd(FLSR_CMD_VIN_OV_RSP, 16'h00C0);
    rd(FLSR_CMD_PG_ON, 16'h2710);
    rd(FLSR_CMD_PG_OFF, 16'h1F40);
    rd(FLSR_CMD_STATUS_WORD, 16'h0840);
    rd(FLSR_CMD_STATUS_IOUT, 16'h0000);
  endtask : t_defaults

  task automatic t_limits;
    logic [7:0] tc [2] = '{FLSR_CMD_TURN_ON_DELAY, FLSR_CMD_TURN_ON_RISE_TIME};
    wc(FLSR_CMD_OT_FAULT_LIM, 16'h0018, 1'b1, 16'h007D);
    wc(FLSR_CMD_OT_FAULT_LIM, 16'h008D, 1'b1, 16'h007D);
    wc(FLSR_CMD_OT_FAULT_LIM, 16'h008C, 1'b0, 16'h008C);
    wc(FLSR_CMD_OT_WARN_LIM, 16'h007E, 1'b1, 16'h006E);
    wc(FLSR_CMD_OT_WARN_LIM, 16'h007D, 1'b0, 16'h007D);
    wc(FLSR_CMD_OT_FAULT_LIM, 16'h007D, 1'b1, 16'h008C);
    wc(FLSR_CMD_OT_WARN_LIM, 16'h0018, 1'b1, 16'h007D);
    wc(FLSR_CMD_OT_WARN_LIM, 16'h0019, 1'b0, 16'h0019);
    wc(FLSR_CMD_OT_FAULT_LIM, 16'h001A, 1'b0, 16'h001A);
    wc(FLSR_CMD_OT_WARN_LIM, 16'h001A, 1'b1, 16'h0019);
    wc(FLSR_CMD_OT_FAULT_LIM, 16'h007D, 1'b0, 16'h007D);
    wc(FLSR_CMD_OT_WARN_LIM, 16'h006E, 1'b0, 16'h006E);
    wc(FLSR_CMD_VIN_OV_LIM, 16'h002F, 1'b1, 16'h0050);
    wc(FLSR_CMD_VIN_OV_LIM, 16'h0030, 1'b0, 16'h0030);
    wc(FLSR_CMD_VIN_OV_LIM, 16'h005B, 1'b1, 16'h0030);
    wc(FLSR_CMD_VIN_OV_LIM, 16'h005A, 1'b0, 16'h005A);
    wc(FLSR_CMD_PG_OFF, 16'h20D1, 1'b1, 16'h1F40);
    wc(FLSR_CMD_PG_OFF, 16'h20D0, 1'b0, 16'h20D0);
    wc(FLSR_CMD_PG_ON, 16'h270F, 1'b1, 16'h2710);
    wc(FLSR_CMD_PG_ON, 16'h3391, 1'b1, 16'h2710);
    wc(FLSR_CMD_PG_ON, 16'h3390, 1'b0, 16'h3390);
    wc(FLSR_CMD_PG_OFF, 16'h0BB7, 1'b1, 16'h20D0);
    wc(FLSR_CMD_PG_OFF, 16'h0BB8, 1'b0, 16'h0BB8);
    wc(FLSR_CMD_PG_ON, 16'h12BF, 1'b1, 16'h3390);
    wc(FLSR_CMD_PG_ON, 16'h12C0, 1'b0, 16'h12C0);
    wc(FLSR_CMD_PG_OFF, 16'h0C81, 1'b1, 16'h0BB8);
    wc(FLSR_CMD_PG_OFF, 16'h0C80, 1'b0, 16'h0C80);
    foreach (tc[i]) begin
      wc(tc[i], 16'h0027, 1'b1, 16'h0028);
      wc(tc[i], 16'h01F4, 1'b0, 16'h01F4);
      wc(tc[i], 16'h01F5, 1'b1, 16'h01F4);
      wc(tc[i], 16'h0028, 1'b0, 16'h0028);
    end
  endtask : t_limits

  task automatic t_status;
    wr(FLSR_CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
    rd(FLSR_CMD_STATUS_WORD, 16'h0840);
    @(posedge clk_sys);
    fault_pins <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    repeat (6) @(posedge clk_sys);
    rd(FLSR_CMD_STATUS_VOUT, 16'h0080);
    rd(FLSR_CMD_STATUS_IOUT, 16'h00A4);
    rd(FLSR_CMD_STATUS_WORD, 16'hEA78);
    @(posedge clk_sys);
    fault_pins <= '0;
    repeat (6) @(posedge clk_sys);
    wc(FLSR_CMD_STATUS_VOUT, 16'h007F, 1'b0, 16'h0080);
    wc(FLSR_CMD_STATUS_VOUT, 16'h0080, 1'b0, 16'h0000);
    wc(FLSR_CMD_STATUS_IOUT, 16'h0020, 1'b0, 16'h0084);
    wc(FLSR_CMD_STATUS_IOUT, 16'h00FF, 1'b0, 16'h0000);
    wr(FLSR_CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
    rd(FLSR_CMD_STATUS_WORD, 16'h0840);
  endtask : t_status

  task automatic t_ot_rsp;
    flsr_rsp_t r;
    flsr_host_i.slow = 3;
    wc(FLSR_CMD_OT_FAULT_RSP, 16'h0000, 1'b0, 16'h0080);
    wc(FLSR_CMD_OT_FAULT_RSP, 16'h0028, 1'b1, 16'h0080);
    wc(FLSR_CMD_OT_FAULT_RSP, 16'h00FF, 1'b0, 16'h00B8);
    wc(FLSR_CMD_VIN_OV_RSP, 16'h0000, 1'b1, 16'h00C0);
    wc(FLSR_CMD_STATUS_WORD, 16'h0000, 1'b1, 16'h0842);
    flsr_host_i.xfer(1'b0, FLSR_CMD_CLEAR_FAULTS, 16'h0000, r);
    check(r, 17'h10000);
    flsr_host_i.slow = 0;
    wr(FLSR_CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
  endtask : t_ot_rsp

  task automatic t_seq;
    int n;
    @(posedge clk_sys);
    fault_pins.on_cmd <= 1'b1;
    sense.vout_mv <= 16'h2EE0;
    #1;
    wait_for(0, 1'b1, 400, n);
    rng(n, 160, 168);
    wait_for(1, 1'b0, 400, n);
    rng(n, 158, 162);
    wait_for(2, 1'b1, 8, n);
    check(17'(power_good), 17'h1);
    @(posedge clk_sys);
    sense.vin_v <= 16'h005F;
    wait_for(0, 1'b0, 8, n);
    rng(n, 1, 6);
    repeat (300) @(posedge clk_sys);
    check(17'(out_enable), 17'h0);
    sense.vin_v <= 16'h0032;
    #1;
    wait_for(0, 1'b1, 400, n);
    rng(n, 160, 168);
    wr(FLSR_CMD_OT_FAULT_RSP, 16'h0000, 1'b0);
    @(posedge clk_sys);
    sense.temp_c <= 16'h0082;
    wait_for(0, 1'b0, 8, n);
    rng(n, 1, 6);
    rd(FLSR_CMD_STATUS_WORD, 16'h2844);
    sense.temp_c <= 16'h001E;
    repeat (400) @(posedge clk_sys);
    check(17'(out_enable), 17'h0);
    fault_pins.on_cmd <= 1'b0;
    repeat (8) @(posedge clk_sys);
    fault_pins.on_cmd <= 1'b1;
    #1;
    wait_for(0, 1'b1, 400, n);
    rng(n, 160, 168);
  endtask : t_seq
  //////////////////////////////////////////////////////////////////////////
  initial begin
    fault_pins = '0;
    sense = '{16'h001E, 16'h0032, 16'h0000};
    // Long enough for the link side to see reset
    repeat (26) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (40) @(posedge clk_sys);
    t_defaults;
    t_limits;
    t_status;
    t_ot_rsp;
    t_seq;
    test_done;
  end
endmodule : flsr_regs_tb

bind flsr_regs flsr_regs_properties #(.CYC_PER_MS(CYC_PER_MS))
  flsr_regs_properties_i (.clk_sys, .sys_rst, .link_clk, .link_req,
  .link_cmd_in, .link_rsp, .link_busy, .link_done, .fault_pins, .sense,
  .out_enable, .out_ramping, .power_good);

// ---- shared/flsr_pkg.sv ----
package flsr_pkg;

  // Command codes on the management link
  localparam logic [7:0] FLSR_CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] FLSR_CMD_OT_FAULT_LIM = 8'h4F;
  localparam logic [7:0] FLSR_CMD_OT_FAULT_RSP = 8'h50;
  localparam logic [7:0] FLSR_CMD_OT_WARN_LIM = 8'h51;
  localparam logic [7:0] FLSR_CMD_VIN_OV_LIM = 8'h55;
  localparam logic [7:0] FLSR_CMD_VIN_OV_RSP = 8'h56;
  localparam logic [7:0] FLSR_CMD_PG_ON = 8'h5E;
  localparam logic [7:0] FLSR_CMD_PG_OFF = 8'h5F;
  localparam logic [7:0] FLSR_CMD_TURN_ON_DELAY = 8'h60;
  localparam logic [7:0] FLSR_CMD_TURN_ON_RISE_TIME = 8'h61;
  localparam logic [7:0] FLSR_CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] FLSR_CMD_STATUS_VOUT = 8'h7A;
  localparam logic [7:0] FLSR_CMD_STATUS_IOUT = 8'h7B;

  // Accepted ranges (deg C, V, mV, ms)
  localparam logic [15:0] FLSR_OT_MIN = 16'h0019;
  localparam logic [15:0] FLSR_OT_FAULT_MAX = 16'h008C;
  localparam logic [15:0] FLSR_OT_WARN_MAX = 16'h007D;
  localparam logic [15:0] FLSR_VIN_OV_MIN = 16'h0030;
  localparam logic [15:0] FLSR_VIN_OV_MAX = 16'h005A;
  localparam logic [15:0] FLSR_PG_ON_MIN = 16'h12C0;
  localparam logic [15:0] FLSR_PG_OFF_MIN = 16'h0BB8;
  localparam logic [15:0] FLSR_PG_MAX = 16'h3390;
  localparam logic [15:0] FLSR_PG_GAP = 16'h0640;
  localparam logic [15:0] FLSR_TON_MIN = 16'h0028;
  localparam logic [15:0] FLSR_TON_MAX = 16'h01F4;

  // Values after reset
  localparam logic [15:0] FLSR_RST_OT_FAULT = 16'h007D;
  localparam logic [15:0] FLSR_RST_OT_WARN = 16'h006E;
  localparam logic [15:0] FLSR_RST_VIN_OV = 16'h0050;
  localparam logic [15:0] FLSR_RST_PG_ON = 16'h2710;
  localparam logic [15:0] FLSR_RST_PG_OFF = 16'h1F40;
  localparam logic [15:0] FLSR_RST_TON = 16'h0028;

  // Response byte fields
  localparam logic [1:0] FLSR_OT_RESPONSE = 2'h2;
  localparam logic [2:0] FLSR_RETRY_NEVER = 3'h0;
  localparam logic [2:0] FLSR_RETRY_ALWAYS = 3'h7;
  localparam logic [2:0] FLSR_NO_DELAY = 3'h0;
  localparam logic [7:0] FLSR_VIN_OV_RSP_VAL = 8'hC0;
  localparam int FLSR_RETRY_LSB = 3;

  // Status field positions
  localparam int FLSR_SW_VOUT = 15;
  localparam int FLSR_SW_IOUT = 14;
  localparam int FLSR_SW_INPUT = 13;
  localparam int FLSR_SW_PG_N = 11;
  localparam int FLSR_SW_OTHER = 9;
  localparam int FLSR_SW_OFF = 6;
  localparam int FLSR_SW_VOUT_OV = 5;
  localparam int FLSR_SW_IOUT_OC = 4;
  localparam int FLSR_SW_VIN_UV = 3;
  localparam int FLSR_SW_TEMP = 2;
  localparam int FLSR_SW_CML = 1;
  localparam int FLSR_SV_OV = 7;
  localparam int FLSR_SI_OC = 7;
  localparam int FLSR_SI_WARN = 5;
  localparam int FLSR_SI_PLIM = 2;

  // Timing
  localparam int FLSR_CLK_PERIOD_NS = 8;
  localparam int FLSR_MS_NS = 1000000;
  localparam int FLSR_CYC_PER_MS = FLSR_MS_NS / FLSR_CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    FLSR_OFF,
    FLSR_DELAY,
    FLSR_RISE,
    FLSR_ON,
    FLSR_LATCHED
  } flsr_seq_t;

  typedef struct packed {
    logic wr;
    logic [7:0] cmd;
    logic [15:0] data;
  } flsr_req_t;

  typedef struct packed {
    logic nack;
    logic [15:0] data;
  } flsr_rsp_t;

  typedef struct packed {
    logic on_cmd;
    logic vout_ov;
    logic iout_oc;
    logic iout_warn;
    logic power_limit;
    logic vin_uv;
    logic other;
  } flsr_pins_t;

  typedef struct packed {
    logic [15:0] temp_c;
    logic [15:0] vin_v;
    logic [15:0] vout_mv;
  } flsr_sense_t;

endpackage : flsr_pkg

// ---- verilog/flsr_regs.sv ----
`timescale 1ns/1ps
module flsr_regs
  import flsr_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = FLSR_CYC_PER_MS
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic link_req,
  input wire flsr_req_t link_cmd_in,
  output flsr_rsp_t link_rsp,
  output logic link_busy,
  output logic link_done,
  input wire flsr_pins_t fault_pins,
  input wire flsr_sense_t sense,
  output logic out_enable,
  output logic out_ramping,
  output logic power_good
);

  if (CYC_PER_MS < 2) begin : g_bad_rate
    $error("CYC_PER_MS must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    flsr_pins_t pin_s1;
    flsr_pins_t pin_s2;
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic ack_tgl;
    flsr_rsp_t rsp;
    logic [15:0] ot_fault_lim;
    logic [2:0] ot_retry;
    logic [15:0] ot_warn_lim;
    logic [15:0] vin_ov_lim;
    logic [15:0] pg_on;
    logic [15:0] pg_off;
    logic [15:0] turn_on_delay;
    logic [15:0] turn_on_rise_time;
    logic vout_ov_f;
    logic iout_oc_f;
    logic iout_warn_f;
    logic plimit_f;
    logic ot_fault_f;
    logic ot_warn_f;
    logic vin_ov_f;
    logic vin_uv_f;
    logic other_f;
    logic cml_f;
    flsr_seq_t seq;
    logic [31:0] tick;
    logic [15:0] ms;
    logic out_en;
    logic ramping;
    logic pgood;
  } flsr_sys_t;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic ack_s1;
    logic ack_s2;
    logic ack_s3;
    logic req_tgl;
    logic busy;
    logic done;
    flsr_req_t req;
    flsr_rsp_t rsp;
  } flsr_link_t;

  flsr_sys_t s_q;
  flsr_sys_t s_d;
  flsr_link_t l_q;
  flsr_link_t l_d;

  function automatic logic in_rng(input logic [15:0] v,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction : in_rng

  function automatic logic gap_ok(input logic [15:0] hi,
                                  input logic [15:0] lo);
    gap_ok = {1'b0, hi} >= ({1'b0, lo} + {1'b0, FLSR_PG_GAP});
  endfunction : gap_ok

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: holds a request stable and toggles it across

  always_comb begin
    l_d = l_q;
    l_d.rst_s1 = sys_rst;
    l_d.rst_s2 = l_q.rst_s1;
    l_d.ack_s1 = s_q.ack_tgl;
    l_d.ack_s2 = l_q.ack_s1;
    l_d.ack_s3 = l_q.ack_s2;
    l_d.done = 1'b0;
    if (!l_q.busy && link_req) begin
      l_d.req = link_cmd_in;
      l_d.req_tgl = ~l_q.req_tgl;
      l_d.busy = 1'b1;
    end else if (l_q.busy && (l_q.ack_s2 != l_q.ack_s3)) begin
      // Answer is stable in the system domain until the next request
      l_d.rsp = s_q.rsp;
      l_d.busy = 1'b0;
      l_d.done = 1'b1;
    end
    if (l_q.rst_s2) begin
      l_d.ack_s1 = 1'b0;
      l_d.ack_s2 = 1'b0;
      l_d.ack_s3 = 1'b0;
      l_d.req_tgl = 1'b0;
      l_d.busy = 1'b0;
      l_d.done = 1'b0;
      l_d.req = '0;
      l_d.rsp = '0;
    end
  end

  always_ff @(posedge link_clk) begin
    l_q <= l_d;
  end

  assign link_rsp = l_q.rsp;
  assign link_busy = l_q.busy;
  assign link_done = l_q.done;

  ////////////////////////////////////////////////////////////////////////////
  // System domain

  logic new_req;
  logic ot_now;
  logic warn_now;
  logic vin_ov_now;
  logic hw_trip;
  logic run_state;
  logic [15:0] word;
  logic [7:0] vout_st;
  logic [7:0] iout_st;
  logic [7:0] ot_rsp;
  logic [15:0] wv;
  logic clr_all;
  logic [7:0] clr_vout;
  logic [7:0] clr_iout;

  always_comb begin
    new_req = s_q.req_s2 != s_q.req_s3;
    ot_now = sense.temp_c >= s_q.ot_fault_lim;
    warn_now = sense.temp_c >= s_q.ot_warn_lim;
    vin_ov_now = sense.vin_v > s_q.vin_ov_lim;
    hw_trip = s_q.pin_s2.vout_ov || s_q.pin_s2.iout_oc;
    run_state = (s_q.seq == FLSR_DELAY) || (s_q.seq == FLSR_RISE) ||
                (s_q.seq == FLSR_ON);
    wv = l_q.req.data;

    ot_rsp = {FLSR_OT_RESPONSE, s_q.ot_retry, FLSR_NO_DELAY};

    vout_st = '0;
    vout_st[FLSR_SV_OV] = s_q.vout_ov_f;
    iout_st = '0;
    iout_st[FLSR_SI_OC] = s_q.iout_oc_f;
    iout_st[FLSR_SI_WARN] = s_q.iout_warn_f;
    iout_st[FLSR_SI_PLIM] = s_q.plimit_f;

    word = '0;
    word[FLSR_SW_VOUT] = |vout_st;
    word[FLSR_SW_IOUT] = |iout_st;
    word[FLSR_SW_INPUT] = s_q.vin_ov_f || s_q.vin_uv_f;
    word[FLSR_SW_PG_N] = ~s_q.pgood;
    word[FLSR_SW_OTHER] = s_q.other_f;
    word[FLSR_SW_OFF] = ~s_q.out_en;
    word[FLSR_SW_VOUT_OV] = s_q.vout_ov_f;
    word[FLSR_SW_IOUT_OC] = s_q.iout_oc_f;
    word[FLSR_SW_VIN_UV] = s_q.vin_uv_f;
    word[FLSR_SW_TEMP] = s_q.ot_fault_f || s_q.ot_warn_f;
    word[FLSR_SW_CML] = s_q.cml_f;

    s_d = s_q;
    s_d.pin_s1 = fault_pins;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.req_s1 = l_q.req_tgl;
    s_d.req_s2 = s_q.req_s1;
    s_d.req_s3 = s_q.req_s2;
    clr_all = 1'b0;
    clr_vout = '0;
    clr_iout = '0;

    ////////////////////////////////////////////////////////////////////////
    // Command execution

    if (new_req) begin
      s_d.rsp = '0;
      s_d.ack_tgl = ~s_q.ack_tgl;
      if (l_q.req.wr) begin
        unique case (l_q.req.cmd)
          FLSR_CMD_CLEAR_FAULTS: clr_all = 1'b1;
          FLSR_CMD_OT_FAULT_LIM: begin
            if (in_rng(wv, FLSR_OT_MIN, FLSR_OT_FAULT_MAX) &&
                (wv > s_q.ot_warn_lim)) begin
              s_d.ot_fault_lim = wv;
            end else begin
              s_d.rsp.nack = 1'b1;
            end
          end
          FLSR_CMD_OT_FAULT_RSP: begin
            if ((wv[FLSR_RETRY_LSB +: 3] == FLSR_RETRY_NEVER) ||
                (wv[FLSR_RETRY_LSB +: 3] == FLSR_RETRY_ALWAYS)) begin
              s_d.ot_retry = wv[FLSR_RETRY_LSB +: 3];
            end else begin
              s_d.rsp.nack = 1'b1;
            end
          end
          FLSR_CMD_OT_WARN_LIM: begin
            if (in_rng(wv, FLSR_OT_MIN, FLSR_OT_WARN_MAX) &&
                (wv < s_q.ot_fault_lim)) begin
              s_d.ot_warn_lim = wv;
            end else begin
              s_d.rsp.nack = 1'b1;
            end
          end
          FLSR_CMD_VIN_OV_LIM: begin
            if (in_rng(wv, FLSR_VIN_OV_MIN, FLSR_VIN_OV_MAX)) begin
              s_d.vin_ov_lim = wv;
            end else begin
              s_d.rsp.nack = 1'b1;
            end
          end
          FLSR_CMD_PG_ON: begin
            if (in_rng(wv, FLSR_PG_ON_MIN, FLSR_PG_MAX) &&
                gap_ok(wv, s_q.pg_off)) begin
              s_d.pg_on = wv;
            end else begin
              s_d.rsp.nack = 1'b1;
            end
          end
          FLSR_CMD_PG_OFF: begin
            if (in_rng(wv, FLSR_PG_OFF_MIN, FLSR_PG_MAX) &&
                gap_ok(s_q.pg_on, wv)) begin
              s_d.pg_off = wv;
            end else begin
              s_d.rsp.nack = 1'b1;
            end
          end
          FLSR_CMD_TURN_ON_DELAY: begin
            if (in_rng(wv, FLSR_TON_MIN, FLSR_TON_MAX)) begin
              s_d.turn_on_delay = wv;
            end else begin
              s_d.rsp.nack = 1'b1;
            end
          end
          FLSR_CMD_TURN_ON_RISE_TIME: begin
            if (in_rng(wv, FLSR_TON_MIN, FLSR_TON_MAX)) begin
              s_d.turn_on_rise_time = wv;
            end else begin
              s_d.rsp.nack = 1'b1;
            end
          end
          // host reset of reported bits only
          FLSR_CMD_STATUS_VOUT: clr_vout = wv[7:0];
          FLSR_CMD_STATUS_IOUT: clr_iout = wv[7:0];
          default: s_d.rsp.nack = 1'b1;
        endcase
      end else begin
        unique case (l_q.req.cmd)
          FLSR_CMD_OT_FAULT_LIM: s_d.rsp.data = s_q.ot_fault_lim;
          FLSR_CMD_OT_FAULT_RSP: s_d.rsp.data = {8'h00, ot_rsp};
          FLSR_CMD_OT_WARN_LIM: s_d.rsp.data = s_q.ot_warn_lim;
          FLSR_CMD_VIN_OV_LIM: s_d.rsp.data = s_q.vin_ov_lim;
          FLSR_CMD_VIN_OV_RSP: s_d.rsp.data = {8'h00, FLSR_VIN_OV_RSP_VAL};
          FLSR_CMD_PG_ON: s_d.rsp.data = s_q.pg_on;
          FLSR_CMD_PG_OFF: s_d.rsp.data = s_q.pg_off;
          FLSR_CMD_TURN_ON_DELAY: s_d.rsp.data = s_q.turn_on_delay;
          FLSR_CMD_TURN_ON_RISE_TIME: s_d.rsp.data = s_q.turn_on_rise_time;
          FLSR_CMD_STATUS_WORD: s_d.rsp.data = word;
          FLSR_CMD_STATUS_VOUT: s_d.rsp.data = {8'h00, vout_st};
          FLSR_CMD_STATUS_IOUT: s_d.rsp.data = {8'h00, iout_st};
          default: s_d.rsp.nack = 1'b1;
        endcase
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags: a new event beats a clear in the same cycle

    s_d.vout_ov_f = (s_q.vout_ov_f && !clr_all && !clr_vout[FLSR_SV_OV]) ||
                    s_q.pin_s2.vout_ov;
    s_d.iout_oc_f = (s_q.iout_oc_f && !clr_all && !clr_iout[FLSR_SI_OC]) ||
                    s_q.pin_s2.iout_oc;
    s_d.iout_warn_f = (s_q.iout_warn_f && !clr_all &&
                       !clr_iout[FLSR_SI_WARN]) || s_q.pin_s2.iout_warn;
    s_d.plimit_f = (s_q.plimit_f && !clr_all && !clr_iout[FLSR_SI_PLIM]) ||
                   s_q.pin_s2.power_limit;
    s_d.ot_fault_f = (s_q.ot_fault_f && !clr_all) || ot_now;
    s_d.ot_warn_f = (s_q.ot_warn_f && !clr_all) || warn_now;
    s_d.vin_ov_f = (s_q.vin_ov_f && !clr_all) || vin_ov_now;
    s_d.vin_uv_f = (s_q.vin_uv_f && !clr_all) || s_q.pin_s2.vin_uv;
    s_d.other_f = (s_q.other_f && !clr_all) || s_q.pin_s2.other;
    s_d.cml_f = (s_q.cml_f && !clr_all) || s_d.rsp.nack;

    ////////////////////////////////////////////////////////////////////////
    // Startup sequencer and fault response

    if (s_q.tick == 32'(CYC_PER_MS - 1)) begin
      s_d.tick = '0;
      s_d.ms = s_q.ms + 16'h0001;
    end else begin
      s_d.tick = s_q.tick + 32'h0000_0001;
    end

    unique case (s_q.seq)
      FLSR_OFF: begin
        // wait for input over-voltage to clear
        if (s_q.pin_s2.on_cmd && !vin_ov_now) begin
          s_d.seq = FLSR_DELAY;
          s_d.tick = '0;
          s_d.ms = '0;
        end
      end
      FLSR_DELAY: begin
        if (s_q.ms >= s_q.turn_on_delay) begin
          s_d.seq = FLSR_RISE;
          s_d.tick = '0;
          s_d.ms = '0;
        end
      end
      FLSR_RISE: begin
        if (s_q.ms >= s_q.turn_on_rise_time) begin
          s_d.seq = FLSR_ON;
        end
      end
      FLSR_ON: begin
      end
      FLSR_LATCHED: begin
        if (!s_q.pin_s2.on_cmd) begin
          s_d.seq = FLSR_OFF;
        end
      end
      // Unused state codes fall back to off
      default: s_d.seq = FLSR_OFF;
    endcase

    if (run_state) begin
      if (!s_q.pin_s2.on_cmd || vin_ov_now || hw_trip) begin
        // output off on command low, input over-voltage or vout_ov/iout_oc trip
        s_d.seq = FLSR_OFF;
      end else if (ot_now) begin
        s_d.seq = (s_q.ot_retry == FLSR_RETRY_NEVER) ? FLSR_LATCHED : FLSR_OFF;
      end
    end

    s_d.out_en = (s_d.seq == FLSR_RISE) || (s_d.seq == FLSR_ON);
    s_d.ramping = s_d.seq == FLSR_RISE;
    if (s_d.seq != FLSR_ON) begin
      s_d.pgood = 1'b0;
    end else if (sense.vout_mv >= s_q.pg_on) begin
      s_d.pgood = 1'b1;
    end else if (sense.vout_mv < s_q.pg_off) begin
      s_d.pgood = 1'b0;
    end

    if (sys_rst) begin
      s_d = '0;
      s_d.ot_fault_lim = FLSR_RST_OT_FAULT;
      s_d.ot_retry = FLSR_RETRY_ALWAYS;
      s_d.ot_warn_lim = FLSR_RST_OT_WARN;
      s_d.vin_ov_lim = FLSR_RST_VIN_OV;
      s_d.pg_on = FLSR_RST_PG_ON;
      s_d.pg_off = FLSR_RST_PG_OFF;
      s_d.turn_on_delay = FLSR_RST_TON;
      s_d.turn_on_rise_time = FLSR_RST_TON;
      s_d.seq = FLSR_OFF;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_q <= s_d;
  end

  assign out_enable = s_q.out_en;
  assign out_ramping = s_q.ramping;
  assign power_good = s_q.pgood;

endmodule : flsr_regs
